// ==== rtl/servo_comp_pkg.sv ====
// constants, field layout and carrier types for the command compensation
// assumes one control clock; one sample strobe per control-loop period
package servo_comp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] OFS_BIAS_SPEED = 8'h00;
    localparam logic [7:0] OFS_BIAS_BAND = 8'h04;
    localparam logic [7:0] OFS_FF_GAIN = 8'h08;
    localparam logic [7:0] OFS_FF_FILT = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_FF_TERM = 8'h18;

    // upper limits of the settings: 450 r/min, 250 units, 100 %, 6400 steps
    localparam logic [15:0] BIAS_SPEED_MAX = 16'h01c2;
    localparam logic [15:0] BIAS_BAND_MAX = 16'h00fa;
    localparam logic [15:0] FF_GAIN_MAX = 16'h0064;
    localparam logic [15:0] FF_FILT_MAX = 16'h1900;

    localparam logic [15:0] BIAS_SPEED_RST = 16'h0000;
    localparam logic [15:0] BIAS_BAND_RST = 16'h0000;
    localparam logic [7:0] FF_GAIN_RST = 8'h00;
    localparam logic [12:0] FF_FILT_RST = 13'h0000;
    localparam logic [3:0] TSEL_RST = 4'h0;

    localparam int CTRL_POS_FF_BIT = 0;
    localparam int CTRL_TSEL_LSB = 4;
    localparam int TSEL_W = 4;
    localparam logic [3:0] TSEL_TORQUE_FF = 4'h2;
    localparam int STATUS_BIAS_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;

    // 655/65536 stands in for 1/100 (0.05 % low)
    localparam logic [9:0] PCT_RECIP = 10'h28f;
    localparam int PCT_SHIFT = 16;
    // filter time constant step, microseconds
    localparam int FILT_STEP_US = 10;

    typedef struct packed {
        logic [31:0] pos_cmd;
        logic [31:0] deviation;
        logic [15:0] speed_cmd;
        logic [15:0] torque_cmd;
        logic [15:0] option_cmd;
    } cmd_in_t;

    typedef struct packed {
        logic [15:0] speed_ref;
        logic [15:0] torque_ref;
    } ref_out_t;

    typedef enum logic [1:0] {
        M_IDLE = 2'b01,
        M_BUSY = 2'b10
    } main_state_t;

    typedef enum logic [3:0] {
        F_IDLE = 4'b0001,
        F_DIV = 4'b0010,
        F_APPLY = 4'b0100,
        F_DONE = 4'b1000
    } filt_state_t;

    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v > 34'sh0_0000_7fff) begin
            sat16 = 16'h7fff;
        end else if (v < 34'sh3_ffff_8000) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction
endpackage

// ==== rtl/ff_lag_filter.sv ====
// first-order lag on the feed-forward term, one update per start
// assumes starts spaced by more than W+12 enabled clocks
`timescale 1ns/1ps
module ff_lag_filter
    import servo_comp_pkg::*;
#(
    parameter int W = 32,
    parameter int STEPS = 10
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [W-1:0] i_x,
    input wire logic [12:0] i_tconst,
    output logic [W-1:0] o_y,
    output logic o_done
);
    localparam int WE = W + 1;
    localparam int NUM_W = W + 9;
    localparam int DEN_W = 14;
    localparam int CNT_W = 6;

    filt_state_t st_q, st_d;
    logic [W-1:0] y_q, y_d;
    logic [NUM_W-1:0] num_q, num_d;
    logic [DEN_W-1:0] rem_q, rem_d, den_q, den_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic neg_q, neg_d, done_q, done_d;
    logic [W:0] err, mag;
    logic [DEN_W:0] trial;

    // y += (x - y) * ts / (t + ts), restoring division one bit per clock;
    // truncation leaves a residue below one step of the divider
    always_comb begin
        st_d = st_q;
        y_d = y_q;
        num_d = num_q;
        rem_d = rem_q;
        den_d = den_q;
        cnt_d = cnt_q;
        neg_d = neg_q;
        done_d = 1'b0;
        err = {i_x[W-1], i_x} - {y_q[W-1], y_q};
        mag = err[W] ? WE'(-err) : err;
        trial = {rem_q, num_q[NUM_W-1]};
        case (st_q)
            F_IDLE: begin
                if (i_start && i_tconst == 13'h0000) begin
                    y_d = i_x;
                    st_d = F_DONE;
                end else if (i_start) begin
                    neg_d = err[W];
                    num_d = NUM_W'(mag) * NUM_W'(STEPS);
                    den_d = DEN_W'(i_tconst) + DEN_W'(STEPS);
                    rem_d = '0;
                    cnt_d = '0;
                    st_d = F_DIV;
                end
            end
            F_DIV: begin
                if (trial >= {1'b0, den_q}) begin
                    rem_d = DEN_W'(trial - {1'b0, den_q});
                    num_d = {num_q[NUM_W-2:0], 1'b1};
                end else begin
                    rem_d = trial[DEN_W-1:0];
                    num_d = {num_q[NUM_W-2:0], 1'b0};
                end
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(NUM_W - 1)) begin
                    st_d = F_APPLY;
                end
            end
            F_APPLY: begin
                y_d = neg_q ? W'({y_q[W-1], y_q} - num_q[W:0])
                            : W'({y_q[W-1], y_q} + num_q[W:0]);
                st_d = F_DONE;
            end
            F_DONE: begin
                done_d = 1'b1;
                st_d = F_IDLE;
            end
            default: st_d = F_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_q <= F_IDLE;
            y_q <= '0;
            num_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            cnt_q <= '0;
            neg_q <= 1'b0;
            done_q <= 1'b0;
        end else if (i_ce) begin
            st_q <= st_d;
            y_q <= y_d;
            num_q <= num_d;
            rem_q <= rem_d;
            den_q <= den_d;
            cnt_q <= cnt_d;
            neg_q <= neg_d;
            done_q <= done_d;
        end
    end

    assign o_y = y_q;
    assign o_done = done_q;

    sequence s_bypass_start;
        i_ce && st_q == F_IDLE && i_start && i_tconst == 13'h0000;
    endsequence

    a_lag_bypass_pass: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_bypass_start ##1 i_ce ##1 i_ce |-> o_done && o_y == $past(i_x, 2))
    else $error("zero time constant did not pass the term through");
endmodule // ff_lag_filter

// ==== rtl/servo_command_compensation.sv ====
// bias injection, position feed-forward and torque feed-forward
// assumes i_sample once per control period, inputs synchronous to clock
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
//
// Function
// - add bias speed while deviation exceeds band
// - stop bias once deviation within band
// - bias speed limited to 0..450 r/min
// - bias band limited to 0..250 units
// - add position command differential to speed
// - scale feed-forward by 0..100 percent gain
// - lag filter, time 0..6400 x 0.01 ms
// - add torque feed-forward to current input
// - select value 2: option value is torque
module servo_command_compensation
    import servo_comp_pkg::*;
#(
    parameter int SAMPLE_US = 100
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_sample,
    input wire cmd_in_t i_cmd,
    output ref_out_t o_ref,
    output logic o_ref_valid,
    output logic o_bias_active
);
    // sample period in filter steps; SAMPLE_US must be at least 10
    localparam int SAMPLE_STEPS = SAMPLE_US / FILT_STEP_US;

    logic [15:0] bias_speed_q, bias_speed_d, bias_band_q, bias_band_d;
    logic [7:0] ff_gain_q, ff_gain_d;
    logic [12:0] ff_filt_q, ff_filt_d;
    logic pos_ff_en_q, pos_ff_en_d;
    logic [3:0] tsel_q, tsel_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    main_state_t st_q, st_d;
    cmd_in_t cmd_q, cmd_d;
    logic [31:0] prev_pos_q, prev_pos_d;
    logic primed_q, primed_d;
    logic bias_active_q, bias_active_d;
    logic [15:0] bias_term_q, bias_term_d;
    ref_out_t ref_q, ref_d;
    logic valid_q, valid_d;

    logic [31:0] dev_abs, filt_x, filt_y;
    logic exceed, filt_start, filt_done;
    logic signed [32:0] pos_diff;
    logic signed [50:0] ff_prod;
    logic [31:0] ff_use;
    logic [15:0] tff_use;

    // writes above the range saturate rather than wrap
    function automatic logic [15:0] clamp16(input logic [31:0] v,
                                            input logic [15:0] maxv);
        if (v > {16'h0000, maxv}) begin
            clamp16 = maxv;
        end else begin
            clamp16 = v[15:0];
        end
    endfunction

    always_comb begin
        bias_speed_d = bias_speed_q;
        bias_band_d = bias_band_q;
        ff_gain_d = ff_gain_q;
        ff_filt_d = ff_filt_q;
        pos_ff_en_d = pos_ff_en_q;
        tsel_d = tsel_q;
        rdata_d = '0;
        if (i_wr) begin
            case (i_addr)
                OFS_BIAS_SPEED:
                    bias_speed_d = clamp16(i_wdata, BIAS_SPEED_MAX);
                OFS_BIAS_BAND:
                    bias_band_d = clamp16(i_wdata, BIAS_BAND_MAX);
                OFS_FF_GAIN:
                    ff_gain_d = 8'(clamp16(i_wdata, FF_GAIN_MAX));
                OFS_FF_FILT:
                    ff_filt_d = 13'(clamp16(i_wdata, FF_FILT_MAX));
                OFS_CTRL: begin
                    pos_ff_en_d = i_wdata[CTRL_POS_FF_BIT];
                    tsel_d = i_wdata[CTRL_TSEL_LSB +: TSEL_W];
                end
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                OFS_BIAS_SPEED: rdata_d = {16'h0000, bias_speed_q};
                OFS_BIAS_BAND: rdata_d = {16'h0000, bias_band_q};
                OFS_FF_GAIN: rdata_d = {24'h000000, ff_gain_q};
                OFS_FF_FILT: rdata_d = {19'h00000, ff_filt_q};
                OFS_CTRL: rdata_d = {24'h000000, tsel_q, 3'b000, pos_ff_en_q};
                OFS_STATUS: begin
                    rdata_d[STATUS_BIAS_BIT] = bias_active_q;
                    rdata_d[STATUS_BUSY_BIT] = (st_q != M_IDLE);
                end
                OFS_FF_TERM: rdata_d = filt_y;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            bias_speed_q <= BIAS_SPEED_RST;
            bias_band_q <= BIAS_BAND_RST;
            ff_gain_q <= FF_GAIN_RST;
            ff_filt_q <= FF_FILT_RST;
            pos_ff_en_q <= 1'b0;
            tsel_q <= TSEL_RST;
            rdata_q <= '0;
        end else if (i_ce) begin
            bias_speed_q <= bias_speed_d;
            bias_band_q <= bias_band_d;
            ff_gain_q <= ff_gain_d;
            ff_filt_q <= ff_filt_d;
            pos_ff_en_q <= pos_ff_en_d;
            tsel_q <= tsel_d;
            rdata_q <= rdata_d;
        end
    end

    // the first sample after reset has no predecessor, so its difference
    // is forced to zero instead of a step from a zero position
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        prev_pos_d = prev_pos_q;
        primed_d = primed_q;
        bias_active_d = bias_active_q;
        bias_term_d = bias_term_q;
        ref_d = ref_q;
        valid_d = 1'b0;
        filt_start = 1'b0;
        dev_abs = i_cmd.deviation[31] ? 32'(-i_cmd.deviation)
                                      : i_cmd.deviation;
        exceed = dev_abs > {16'h0000, bias_band_q};
        pos_diff = $signed({i_cmd.pos_cmd[31], i_cmd.pos_cmd})
                 - $signed({prev_pos_q[31], prev_pos_q});
        ff_prod = pos_diff * $signed({1'b0, ff_gain_q})
                * $signed({1'b0, PCT_RECIP});
        filt_x = primed_q ? ff_prod[PCT_SHIFT +: 32] : 32'h00000000;
        ff_use = pos_ff_en_q ? filt_y : 32'h00000000;
        tff_use = (tsel_q == TSEL_TORQUE_FF) ? cmd_q.option_cmd
                                             : 16'h0000;
        case (st_q)
            M_IDLE: begin
                if (i_sample) begin
                    cmd_d = i_cmd;
                    prev_pos_d = i_cmd.pos_cmd;
                    primed_d = 1'b1;
                    bias_active_d = exceed;
                    if (!exceed) begin
                        bias_term_d = 16'h0000;
                    end else if (i_cmd.deviation[31]) begin
                        bias_term_d = 16'(-bias_speed_q);
                    end else begin
                        bias_term_d = bias_speed_q;
                    end
                    filt_start = 1'b1;
                    st_d = M_BUSY;
                end
            end
            M_BUSY: begin
                if (filt_done) begin
                    ref_d.speed_ref = sat16(34'($signed(cmd_q.speed_cmd))
                                    + 34'($signed(ff_use))
                                    + 34'($signed(bias_term_q)));
                    ref_d.torque_ref = sat16(34'($signed(cmd_q.torque_cmd))
                                     + 34'($signed(tff_use)));
                    valid_d = 1'b1;
                    st_d = M_IDLE;
                end
            end
            default: st_d = M_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_q <= M_IDLE;
            cmd_q <= '0;
            prev_pos_q <= '0;
            primed_q <= 1'b0;
            bias_active_q <= 1'b0;
            bias_term_q <= '0;
            ref_q <= '0;
            valid_q <= 1'b0;
        end else if (i_ce) begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            prev_pos_q <= prev_pos_d;
            primed_q <= primed_d;
            bias_active_q <= bias_active_d;
            bias_term_q <= bias_term_d;
            ref_q <= ref_d;
            valid_q <= valid_d;
        end
    end

    ff_lag_filter #(
        .W(32),
        .STEPS(SAMPLE_STEPS)
    ) u_lag (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_start(filt_start),
        .i_x(filt_x),
        .i_tconst(ff_filt_q),
        .o_y(filt_y),
        .o_done(filt_done)
    );

    assign o_rdata = rdata_q;
    assign o_ref = ref_q;
    assign o_ref_valid = valid_q;
    assign o_bias_active = bias_active_q;

    sequence s_take;
        i_ce && st_q == M_IDLE && i_sample;
    endsequence

    a_bias_speed_clamp: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && i_wr && i_addr == OFS_BIAS_SPEED && i_wdata > 32'h1c2
        |=> bias_speed_q == 16'h01c2)
    else $error("bias speed above range not held at 450");
    a_bias_band_clamp: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && i_wr && i_addr == OFS_BIAS_BAND
        |=> bias_band_q <= 16'h00fa && (bias_band_q == 16'h00fa
            || bias_band_q == $past(i_wdata[15:0])))
    else $error("bias band write out of range");
    a_gain_clamp: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        ff_gain_q <= 8'h64)
    else $error("feed-forward gain above 100");
    a_filt_clamp: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && i_wr && i_addr == OFS_FF_FILT && i_wdata > 32'h1900
        |=> ff_filt_q == 13'h1900)
    else $error("filter time above range not held at 6400");
    a_bias_apply_on: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_take ##0 exceed |=> bias_active_q && bias_term_q ==
            ($past(i_cmd.deviation[31]) ? 16'(-bias_speed_q)
                                        : bias_speed_q))
    else $error("bias not applied with deviation sign");
    a_bias_apply_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_take ##0 !exceed |=> !o_bias_active && bias_term_q == 16'h0000)
    else $error("bias kept inside the band");
    a_tff_select: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_ref_valid && tsel_q != TSEL_TORQUE_FF
        |-> o_ref.torque_ref == cmd_q.torque_cmd)
    else $error("torque term added without select 2");
    a_ff_disabled: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_ref_valid && !pos_ff_en_q && bias_term_q == 16'h0000
        |-> o_ref.speed_ref == cmd_q.speed_cmd)
    else $error("speed changed with feed-forward and bias off");
    a_valid_pulse: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_ref_valid && i_ce |=> !o_ref_valid)
    else $error("reference valid longer than one cycle");
endmodule // servo_command_compensation

// ==== dv/host_ctrl_model.sv ====
// host controller model: one sample strobe and command set per request
// assumes requests come no closer than the device's sample spacing
`timescale 1ns/1ps
module host_ctrl_model
    import servo_comp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_go,
    input wire logic [31:0] i_pos,
    input wire logic [31:0] i_dev,
    input wire logic [15:0] i_speed,
    input wire logic [15:0] i_torque,
    output logic o_sample,
    output cmd_in_t o_cmd
);
    logic [15:0] prev_speed_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_sample <= 1'b0;
            o_cmd <= '0;
            prev_speed_q <= 16'h0000;
        end else begin
            o_sample <= i_go;
            if (i_go) begin
                o_cmd.pos_cmd <= i_pos;
                o_cmd.deviation <= i_dev;
                o_cmd.speed_cmd <= i_speed;
                o_cmd.torque_cmd <= i_torque;
                // differential of speed: zero while speed holds steady
                o_cmd.option_cmd <= i_speed - prev_speed_q;
                prev_speed_q <= i_speed;
            end
        end
    end
endmodule // host_ctrl_model

// ==== dv/tb_servo_command_compensation.sv ====
// self-checking bench for the command compensation block
// assumes the host model feeds the sample path, the bench the registers
`timescale 1ns/1ps
module tb_servo_command_compensation
    import servo_comp_pkg::*;
;
    localparam int SAMPLE_US = 100;
    localparam int S = SAMPLE_US / FILT_STEP_US;
    logic i_sys_clk, i_resetn, i_wr, i_rd, go, samp_s, i_ce;
    logic o_ref_valid, o_bias_active;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, pos, dev;
    logic [15:0] spd, trq, last_spd;
    cmd_in_t cmd;
    ref_out_t o_ref;
    int n_mismatch = 0;
    int checks_done = 0;
    int y = 0;
    int lat = 0;

    servo_command_compensation #(.SAMPLE_US(SAMPLE_US)) i_dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_sample(samp_s), .i_cmd(cmd), .o_ref(o_ref),
        .o_ref_valid(o_ref_valid), .o_bias_active(o_bias_active));

    host_ctrl_model i_host (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_go(go), .i_pos(pos),
        .i_dev(dev), .i_speed(spd), .i_torque(trq), .o_sample(samp_s),
        .o_cmd(cmd));

    task automatic stop_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        d = o_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        rd(a, r);
        chk(r, e);
    endtask

    // spacing of 46 cycles keeps every request clear of a busy block
    task automatic samp(input logic [31:0] p, dv, input logic [15:0] s, t);
        int k;
        repeat (46) @(posedge i_sys_clk);
        go <= 1'b1;
        pos <= p;
        dev <= dv;
        spd <= s;
        trq <= t;
        @(posedge i_sys_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge i_sys_clk);
            k++;
        end while (o_ref_valid !== 1'b1 && k < 100);
        chk({31'h0, o_ref_valid}, 32'h1);
        @(negedge i_sys_clk);
        chk({31'h0, o_ref_valid}, 32'h0);
        last_spd = s;
        lat = k;
    endtask

    function automatic int ffx(input int d, input int g);
        longint m;
        m = longint'(d) * g * 655;
        return int'(m >>> 16);
    endfunction

    task automatic t_regs();
        logic [7:0] ofs [4] = '{OFS_BIAS_SPEED, OFS_BIAS_BAND, OFS_FF_GAIN,
                                OFS_FF_FILT};
        logic [31:0] hi [4] = '{32'h1f4, 32'h12c, 32'hc8, 32'h1b58};
        logic [15:0] mx [4] = '{BIAS_SPEED_MAX, BIAS_BAND_MAX, FF_GAIN_MAX,
                                FF_FILT_MAX};
        for (int a = 0; a < 32; a += 4) begin
            rchk(8'(a), 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            wr(ofs[i], hi[i]);
            rchk(ofs[i], {16'h0, mx[i]});
            wr(ofs[i], 32'h0);
            rchk(ofs[i], 32'h0);
        end
        wr(OFS_CTRL, 32'h21);
        rchk(OFS_CTRL, 32'h21);
        wr(OFS_STATUS, 32'h3);
        rchk(OFS_STATUS, 32'h0);
        wr(OFS_FF_TERM, 32'h55);
        rchk(OFS_FF_TERM, 32'h0);
        wr(8'h1c, 32'h55);
        rchk(8'h1c, 32'h0);
    endtask

    task automatic t_bias();
        int bd [10] = '{10, 10, 10, 10, 10, 0, 0, 0, 250, 250};
        int bs [10] = '{100, 100, 100, 100, 100, 100, 100, 0, 450, 450};
        int dv [10] = '{11, -11, 10, -10, 11, 1, 0, 500, 251, -250};
        int sp [10] = '{5, 5, 5, 5, 32752, 0, 0, 5, 0, 0};
        int ex [10] = '{105, -95, 5, 5, 32767, 100, 0, 5, 450, 0};
        bit ac [10] = '{1, 1, 0, 0, 1, 1, 0, 1, 1, 0};
        logic [15:0] e;
        logic [31:0] r;
        wr(OFS_CTRL, 32'h0);
        for (int i = 0; i < 10; i++) begin
            wr(OFS_BIAS_BAND, 32'(bd[i]));
            wr(OFS_BIAS_SPEED, 32'(bs[i]));
            samp(32'h0, 32'(dv[i]), 16'(sp[i]), 16'h0000);
            e = 16'(ex[i]);
            chk({16'h0, o_ref.speed_ref}, {16'h0, e});
            rd(OFS_STATUS, r);
            chk({31'h0, o_bias_active}, {31'h0, ac[i]});
            chk(r & 32'h1, {31'h0, ac[i]});
        end
    endtask

    task automatic t_torque();
        logic [15:0] s, o;
        for (int sel = 0; sel < 4; sel++) begin
            wr(OFS_CTRL, 32'(sel) << 4);
            for (int j = 0; j < 2; j++) begin
                s = last_spd + ((j == 0) ? 16'h0020 : 16'h0000);
                o = (sel == 2) ? s - last_spd : 16'h0000;
                samp(32'h0, 32'h0, s, 16'h0100);
                chk({16'h0, o_ref.torque_ref}, 32'h100 + o);
            end
        end
    endtask

    task automatic t_ff();
        int ps [7] = '{1000, 2000, 1000, 1000, 1000, 3000, 3000};
        int gn [7] = '{80, 100, 50, 50, 50, 100, 0};
        int tc [7] = '{0, 0, 0, 10, 10, 6400, 0};
        int x, pp;
        logic [15:0] e;
        pp = 0;
        wr(OFS_BIAS_SPEED, 32'h0);
        wr(OFS_CTRL, 32'h1);
        for (int i = 0; i < 7; i++) begin
            wr(OFS_FF_GAIN, 32'(gn[i]));
            wr(OFS_FF_FILT, 32'(tc[i]));
            x = ffx(ps[i] - pp, gn[i]);
            y = (tc[i] == 0) ? x : y + (x - y) * S / (tc[i] + S);
            pp = ps[i];
            samp(32'(ps[i]), 32'h0, 16'h0000, 16'h0000);
            e = 16'(y);
            chk({16'h0, o_ref.speed_ref}, {16'h0, e});
            rchk(OFS_FF_TERM, 32'(y));
            chk(32'(lat), (tc[i] == 0) ? 32'd4 : 32'd46);
        end
        // with the enable off the position step must not reach speed
        wr(OFS_CTRL, 32'h0);
        samp(32'd5000, 32'h0, 16'h0011, 16'h0000);
        chk({16'h0, o_ref.speed_ref}, 32'h0011);
        wr(OFS_FF_FILT, 32'h0);
    endtask

    // a frozen enable stretches the answer by the frozen cycles only
    task automatic t_ce();
        int k;
        logic [31:0] r;
        wr(OFS_FF_FILT, 32'h1);
        repeat (46) @(posedge i_sys_clk);
        go <= 1'b1;
        spd <= 16'h0033;
        @(posedge i_sys_clk);
        go <= 1'b0;
        rd(OFS_STATUS, r);
        chk(r, 32'h2);
        @(posedge i_sys_clk);
        i_ce <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        i_ce <= 1'b1;
        k = 0;
        do begin
            @(negedge i_sys_clk);
            k++;
        end while (o_ref_valid !== 1'b1 && k < 100);
        // 44 enabled edges from the take, two of them before the freeze
        chk(32'(k), 32'd43);
        chk({16'h0, o_ref.speed_ref}, 32'h0033);
        wr(OFS_FF_FILT, 32'h0);
    endtask

    // a reset in mid-run clears settings, outputs and the first difference
    task automatic t_rst();
        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(negedge i_sys_clk);
        chk(32'(o_ref), 32'h0);
        chk({31'h0, o_bias_active}, 32'h0);
        rchk(OFS_BIAS_BAND, 32'h0);
        wr(OFS_FF_GAIN, 32'd100);
        wr(OFS_CTRL, 32'h1);
        samp(32'd7000, 32'h0, 16'h0000, 16'h0000);
        chk({16'h0, o_ref.speed_ref}, 32'h0);
        samp(32'd7100, 32'h0, 16'h0000, 16'h0000);
        chk({16'h0, o_ref.speed_ref}, 32'(ffx(100, 100)));
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // whole run is near 1900 cycles; 20000 leaves ample margin
    initial begin
        #1_000_000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        i_resetn = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_ce = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        go = 1'b0;
        pos = 32'h0;
        dev = 32'h0;
        spd = 16'h0000;
        trq = 16'h0000;
        last_spd = 16'h0000;
        repeat (4) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_bias();
        t_torque();
        t_ff();
        t_ce();
        t_rst();
        stop_test();
    end
endmodule // tb_servo_command_compensation
